// ===== uefc_pkg.sv
package uefc_pkg;
    // Register indices on the plain port (4-bit address)
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h1;
    localparam logic [3:0] ADDR_INT_SOURCE = 4'h2;
    localparam logic [3:0] ADDR_FIFO_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_MODEM_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_MODEM_STATUS = 4'h6;
    localparam logic [3:0] ADDR_SCRATCH = 4'h7;
    localparam logic [3:0] ADDR_FEATURE = 4'h8;
    localparam logic [3:0] ADDR_ENH_FEATURE = 4'h9;
    localparam logic [3:0] ADDR_RES1 = 4'hA;
    localparam logic [3:0] ADDR_RES2 = 4'hB;
    localparam logic [3:0] ADDR_PAU1 = 4'hC;
    localparam logic [3:0] ADDR_PAU2 = 4'hD;
    localparam logic [3:0] ADDR_STAT = 4'hE;
    // Reset values
    localparam logic [7:0] SCRATCH_RESET = 8'hFF;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    // Gated enhanced bit masks
    localparam logic [7:0] INT_ENABLE_ENH_MASK = 8'hF0;
    localparam logic [7:0] INT_SOURCE_ENH_MASK = 8'h30;
    localparam logic [7:0] FIFO_CONTROL_ENH_MASK = 8'h30;
    localparam logic [7:0] MODEM_CONTROL_ENH_MASK = 8'hE0;
    // Field positions
    localparam int FEAT_IRPOL = 4;
    localparam int FEAT_RS485 = 5;
    localparam int ENH_ENABLE_BIT = 4;
    localparam int ENH_SPECIAL_BIT = 5;
    localparam logic [1:0] TABLE_D = 2'b11;
    // Hysteresis decode in characters
    localparam logic [5:0] HYST_TABLE [16] = '{6'd0, 6'd4, 6'd6, 6'd8, 6'd8, 6'd16, 6'd24,
        6'd32, 6'd40, 6'd44, 6'd48, 6'd52, 6'd12, 6'd20, 6'd28, 6'd36};
    // Default neighbour trigger step
    localparam logic [7:0] FIFO_STEP = 8'h04;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uefc_bus_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } uefc_char_t;

    typedef enum logic [1:0] {
        DIR_RECEIVE,
        DIR_SEND,
        DIR_TURN
    } uefc_dir_t;
endpackage

// ===== uefc_top.sv
////////////////////////////////////////////////////////////////////////////////
module uefc_top #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire uefc_pkg::uefc_bus_t bus,
    output logic [7:0] rdata,
    input wire logic irRxIn,
    output logic irRxDecoded,
    input wire logic bitTick,
    input wire logic txLoad,
    input wire logic holdEmpty,
    input wire logic shiftEmpty,
    input wire logic [7:0] rxLevel,
    input wire logic [7:0] rxTrigger,
    input wire logic [7:0] trigStep,
    input wire uefc_pkg::uefc_char_t rxChar,
    output logic rxStore,
    output logic resumeSeen,
    output logic pauseSeen,
    output logic specialSeen,
    output logic [1:0] txFlowSel,
    output logic txIntCond,
    output logic rtsFlowOff,
    output logic rtsN,
    output logic [7:0] intEnableOut,
    output logic [7:0] fifoControlOut,
    output logic [7:0] modemControlOut
);
    import uefc_pkg::*;

    if (DATA_W != 8)
    begin : g_width_check
        $error("uefc_top supports 8-bit characters only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin sync
    logic rstMeta, rstSync;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    logic irMeta, irSync;
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            irMeta <= 1'b0;
            irSync <= 1'b0;
        end
        else
        begin
            irMeta <= irRxIn;
            irSync <= irMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] scratchStore, featureControl, enhancedFeatureControl;
    logic [7:0] resumeCharFirst, resumeCharSecond, pauseCharFirst, pauseCharSecond;
    logic [3:0] turnDelay;
    logic [7:0] intEnableEnh, intSourceEnh, fifoControlEnh, modemControlEnh;
    logic enhEnable;
    logic wrScratch, wrEnh;
    logic specialFlag, pauseFlag;
    logic [1:0] rxCode;

    assign enhEnable = enhancedFeatureControl[ENH_ENABLE_BIT];
    assign wrScratch = bus.wr && bus.addr == ADDR_SCRATCH;
    assign wrEnh = bus.wr && enhEnable;
    assign txFlowSel = enhancedFeatureControl[3:2];
    assign rxCode = enhancedFeatureControl[1:0];

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            scratchStore <= SCRATCH_RESET;
        end
        else if (wrScratch)
        begin
            scratchStore <= bus.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            featureControl <= ZERO_RESET;
            enhancedFeatureControl <= ZERO_RESET;
            resumeCharFirst <= ZERO_RESET;
            resumeCharSecond <= ZERO_RESET;
            pauseCharFirst <= ZERO_RESET;
            pauseCharSecond <= ZERO_RESET;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                ADDR_FEATURE: featureControl <= bus.wdata;
                ADDR_ENH_FEATURE: enhancedFeatureControl <= bus.wdata;
                ADDR_RES1: resumeCharFirst <= bus.wdata;
                ADDR_RES2: resumeCharSecond <= bus.wdata;
                ADDR_PAU1: pauseCharFirst <= bus.wdata;
                ADDR_PAU2: pauseCharSecond <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Enhanced bits latch while enable is low; legacy writers cannot touch them
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            intEnableEnh <= ZERO_RESET;
            fifoControlEnh <= ZERO_RESET;
            modemControlEnh <= ZERO_RESET;
            turnDelay <= 4'h0;
        end
        else if (wrEnh)
        begin
            case (bus.addr)
                ADDR_INT_ENABLE: intEnableEnh <= bus.wdata & INT_ENABLE_ENH_MASK;
                ADDR_FIFO_CONTROL: fifoControlEnh <= bus.wdata & FIFO_CONTROL_ENH_MASK;
                ADDR_MODEM_CONTROL: modemControlEnh <= bus.wdata & MODEM_CONTROL_ENH_MASK;
                ADDR_MODEM_STATUS: turnDelay <= bus.wdata[7:4];
                default: ;
            endcase
        end
    end

    // Status bits: hardware set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            intSourceEnh <= ZERO_RESET;
        end
        else
        begin
            intSourceEnh[4] <= specialFlag
                | (intSourceEnh[4] & ~(bus.rd && bus.addr == ADDR_INT_SOURCE));
            intSourceEnh[5] <= pauseFlag
                | (intSourceEnh[5] & ~(bus.rd && bus.addr == ADDR_INT_SOURCE));
        end
    end

    assign intEnableOut = intEnableEnh;
    assign fifoControlOut = fifoControlEnh;
    assign modemControlOut = modemControlEnh;

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            rdata <= ZERO_RESET;
        end
        else if (bus.rd)
        begin
            case (bus.addr)
                ADDR_INT_ENABLE: rdata <= intEnableEnh;
                ADDR_INT_SOURCE: rdata <= intSourceEnh;
                ADDR_MODEM_CONTROL: rdata <= modemControlEnh;
                ADDR_SCRATCH: rdata <= scratchStore;
                ADDR_FEATURE: rdata <= featureControl;
                ADDR_ENH_FEATURE: rdata <= enhancedFeatureControl;
                ADDR_RES1: rdata <= resumeCharFirst;
                ADDR_RES2: rdata <= resumeCharSecond;
                ADDR_PAU1: rdata <= pauseCharFirst;
                ADDR_PAU2: rdata <= pauseCharSecond;
                ADDR_STAT: rdata <= {5'h0, rtsN, rtsFlowOff, txIntCond};
                default: rdata <= ZERO_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Infrared polarity
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            irRxDecoded <= 1'b0;
        end
        else
        begin
            irRxDecoded <= irSync ^ featureControl[FEAT_IRPOL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hardware flow threshold
    logic [7:0] hystChars, offLevel, onLevel;
    logic useTableD;
    assign useTableD = featureControl[7:6] == TABLE_D;
    always_comb
    begin
        hystChars = {2'b00, HYST_TABLE[featureControl[3:0]]};
        if (useTableD && featureControl[3:0] != 4'h0)
        begin
            offLevel = rxTrigger + hystChars;
            onLevel = (rxTrigger > hystChars) ? rxTrigger - hystChars : 8'h00;
        end
        else
        begin
            offLevel = rxTrigger + trigStep;
            onLevel = (rxTrigger > trigStep) ? rxTrigger - trigStep : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            rtsFlowOff <= 1'b0;
        end
        else if (rxLevel >= offLevel)
        begin
            rtsFlowOff <= 1'b1;
        end
        else if (rxLevel < onLevel)
        begin
            rtsFlowOff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RS-485 direction control
    uefc_dir_t dirState;
    logic [3:0] turnCount;
    logic rs485;
    assign rs485 = featureControl[FEAT_RS485];
    assign txIntCond = rs485 ? shiftEmpty : holdEmpty;

    // Off counts as sending, so enabling over an idle line turns around
    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            dirState <= DIR_SEND;
            turnCount <= 4'h0;
            rtsN <= 1'b1;
        end
        else if (!rs485)
        begin
            dirState <= DIR_SEND;
            rtsN <= 1'b1;
        end
        else
        begin
            case (dirState)
                DIR_RECEIVE:
                    if (txLoad)
                    begin
                        rtsN <= 1'b1;
                        dirState <= DIR_SEND;
                    end
                DIR_SEND:
                    if (shiftEmpty && holdEmpty && !txLoad)
                    begin
                        turnCount <= turnDelay;
                        if (turnDelay == 4'h0)
                        begin
                            rtsN <= 1'b0;
                            dirState <= DIR_RECEIVE;
                        end
                        else
                        begin
                            dirState <= DIR_TURN;
                        end
                    end
                DIR_TURN:
                    if (txLoad)
                    begin
                        dirState <= DIR_SEND;
                    end
                    else if (bitTick)
                    begin
                        if (turnCount == 4'h1)
                        begin
                            rtsN <= 1'b0;
                            dirState <= DIR_RECEIVE;
                        end
                        turnCount <= turnCount - 4'h1;
                    end
                default: dirState <= DIR_RECEIVE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software flow and special character detection
    logic [7:0] prevChar;
    logic prevValid;
    logic mRes1, mRes2, mPau1, mPau2, seqRes, seqPau, single, dual;
    assign mRes1 = rxChar.data == resumeCharFirst;
    assign mRes2 = rxChar.data == resumeCharSecond;
    assign mPau1 = rxChar.data == pauseCharFirst;
    assign mPau2 = rxChar.data == pauseCharSecond;
    assign seqRes = prevValid && prevChar == resumeCharFirst && mRes2;
    assign seqPau = prevValid && prevChar == pauseCharFirst && mPau2;
    assign dual = txFlowSel == 2'b11 || txFlowSel == 2'b00;

    always_comb
    begin
        single = 1'b0;
        resumeSeen = 1'b0;
        pauseSeen = 1'b0;
        if (rxChar.valid)
        begin
            case (rxCode)
                2'b10:
                begin
                    resumeSeen = mRes1;
                    pauseSeen = mPau1;
                end
                2'b01:
                begin
                    resumeSeen = mRes2;
                    pauseSeen = mPau2;
                end
                2'b11:
                begin
                    single = !dual;
                    resumeSeen = single ? (mRes1 | mRes2) : seqRes;
                    pauseSeen = single ? (mPau1 | mPau2) : seqPau;
                end
                default: ;
            endcase
        end
    end

    // Only a code 01 special match is kept out of the FIFO
    always_comb
    begin
        specialFlag = rxChar.valid && enhancedFeatureControl[ENH_SPECIAL_BIT] && mPau2;
        pauseFlag = pauseSeen;
        rxStore = rxChar.valid && !(rxCode == 2'b01 && specialFlag);
    end
    assign specialSeen = specialFlag;

    always_ff @(posedge clk or negedge rstSync)
    begin
        if (!rstSync)
        begin
            prevChar <= ZERO_RESET;
            prevValid <= 1'b0;
        end
        else if (rxChar.valid)
        begin
            prevChar <= rxChar.data;
            prevValid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_scratch_reset;
        @(posedge clk) $rose(rstSync) |-> scratchStore == SCRATCH_RESET;
    endproperty
    a_scratch_reset: assert property (p_scratch_reset) else $error("scratch not all ones");

    property p_scratch_rw;
        @(posedge clk) disable iff (!rstSync)
        wrScratch ##1 !bus.wr ##1 (bus.rd && bus.addr == ADDR_SCRATCH)
            |=> rdata == $past(bus.wdata, 3);
    endproperty
    a_scratch_rw: assert property (p_scratch_rw) else $error("scratch readback wrong");

    property p_enh_gate;
        @(posedge clk) disable iff (!rstSync)
        (bus.wr && !enhEnable && bus.addr == ADDR_INT_ENABLE) |=> $stable(intEnableEnh);
    endproperty
    a_enh_gate: assert property (p_enh_gate) else $error("gated bits changed");

    // Holding empty while shifting is where the two interrupt sources differ
    property p_txint;
        @(posedge clk) disable iff (!rstSync)
        (holdEmpty && !shiftEmpty) |-> txIntCond == !rs485;
    endproperty
    a_txint: assert property (p_txint) else $error("tx interrupt source wrong");

    property p_rts_load;
        @(posedge clk) disable iff (!rstSync)
        (rs485 && dirState == DIR_RECEIVE && txLoad) |=> rtsN;
    endproperty
    a_rts_load: assert property (p_rts_load) else $error("rts not raised on load");

    property p_rts_drop;
        @(posedge clk) disable iff (!rstSync)
        (rs485 && dirState == DIR_SEND && shiftEmpty && holdEmpty && !txLoad
            && turnDelay == 4'h0) |=> !rtsN;
    endproperty
    a_rts_drop: assert property (p_rts_drop) else $error("rts not dropped");

    property p_ir;
        @(posedge clk) disable iff (!rstSync)
        irRxDecoded == ($past(irSync) ^ $past(featureControl[FEAT_IRPOL]));
    endproperty
    a_ir: assert property (p_ir) else $error("ir polarity wrong");

    property p_special;
        @(posedge clk) disable iff (!rstSync)
        specialFlag |=> intSourceEnh[4];
    endproperty
    a_special: assert property (p_special) else $error("special flag lost");

    property p_swallow;
        @(posedge clk) disable iff (!rstSync)
        (specialFlag && rxCode == 2'b01) |-> !rxStore && pauseSeen;
    endproperty
    a_swallow: assert property (p_swallow) else $error("code 01 special stored");

    c_turn: cover property (@(posedge clk) dirState == DIR_TURN ##[1:300] dirState == DIR_RECEIVE);
    c_seq: cover property (@(posedge clk) seqPau && rxCode == 2'b11);
    c_flow: cover property (@(posedge clk) $rose(rtsFlowOff) && useTableD);
endmodule // uefc_top

// ===== uefc_partner.sv
module uefc_partner (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sendReq,
    output logic txLoad,
    output logic holdEmpty,
    output logic shiftEmpty,
    output logic bitTick
);
    logic [1:0] div;
    logic [3:0] bitsLeft;
    ////////////////////////////////////////////////////////////////////////////
    // Baud logic runs free, one tick every four clocks
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            div <= 2'h0;
        else
            div <= div + 2'h1;
    end
    assign bitTick = (div == 2'h3);
    ////////////////////////////////////////////////////////////////////////////
    // One frame: start, eight data, stop; holding empties on the first tick
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            txLoad <= 1'b0;
            holdEmpty <= 1'b1;
            shiftEmpty <= 1'b1;
            bitsLeft <= 4'h0;
        end
        else
        begin
            txLoad <= sendReq;
            if (sendReq)
            begin
                holdEmpty <= 1'b0;
                shiftEmpty <= 1'b0;
                bitsLeft <= 4'hA;
            end
            else if (bitTick && bitsLeft != 4'h0)
            begin
                holdEmpty <= 1'b1;
                bitsLeft <= bitsLeft - 4'h1;
                if (bitsLeft == 4'h1)
                    shiftEmpty <= 1'b1;
            end
        end
    end
endmodule // uefc_partner

// ===== uefc_top_tb.sv
module uefc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uefc_pkg::*;
    logic clk, rstn, irRxIn, sendReq, txLoad, holdEmpty, shiftEmpty, bitTick, spec;
    uefc_bus_t bus;
    uefc_char_t rxChar;
    logic [7:0] rdata, rxLevel, rxTrigger, trigStep, intEnableOut, fifoControlOut, v;
    logic [7:0] modemControlOut;
    logic irRxDecoded, rxStore, resumeSeen, pauseSeen, specialSeen, txIntCond;
    logic rtsFlowOff, rtsN;
    logic [1:0] txFlowSel;
    logic [2:0] seen;
    logic [7:0] hy [16] = '{8'h00, 8'h04, 8'h06, 8'h08, 8'h08, 8'h10, 8'h18, 8'h20,
        8'h28, 8'h2C, 8'h30, 8'h34, 8'h0C, 8'h14, 8'h1C, 8'h24};
    int err_total = 0;
    int checks_done = 0;
    uefc_top i_dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .irRxIn(irRxIn),
        .irRxDecoded(irRxDecoded), .bitTick(bitTick), .txLoad(txLoad),
        .holdEmpty(holdEmpty), .shiftEmpty(shiftEmpty), .rxLevel(rxLevel),
        .rxTrigger(rxTrigger), .trigStep(trigStep), .rxChar(rxChar), .rxStore(rxStore),
        .resumeSeen(resumeSeen), .pauseSeen(pauseSeen), .specialSeen(specialSeen),
        .txFlowSel(txFlowSel), .txIntCond(txIntCond), .rtsFlowOff(rtsFlowOff),
        .rtsN(rtsN), .intEnableOut(intEnableOut), .fifoControlOut(fifoControlOut),
        .modemControlOut(modemControlOut));
    uefc_partner i_far (.clk(clk), .rstn(rstn), .sendReq(sendReq), .txLoad(txLoad),
        .holdEmpty(holdEmpty), .shiftEmpty(shiftEmpty), .bitTick(bitTick));
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen8, input logic [7:0] exp);
        checks_done++;
        if (seen8 !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen8);
        end
    endtask
    task automatic waitclk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // A spare edge after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        waitclk(1);
        bus <= '0;
        waitclk(1);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        waitclk(1);
        bus <= '0;
        #1 d = rdata;
        waitclk(1);
    endtask
    // Flow bits cleared before any new setting
    task automatic setEnhFeature(input logic [7:0] d);
        wr(ADDR_ENH_FEATURE, d & 8'hF0);
        wr(ADDR_ENH_FEATURE, d);
    endtask
    // Flags are sampled before the edge that stores the character
    task automatic sendc(input logic [7:0] d);
        rxChar <= '{data: d, valid: 1'b1};
        #1 seen = {rxStore, resumeSeen, pauseSeen};
        spec = specialSeen;
        waitclk(1);
        rxChar <= '{data: 8'h00, valid: 1'b0};
        waitclk(1);
    endtask
    task automatic level(input logic [7:0] l, input logic exp);
        rxLevel <= l;
        waitclk(3);
        chk("rtsFlowOff", {7'h0, rtsFlowOff}, {7'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            do
            begin
                @(posedge clk);
                #1;
            end while (bitTick !== 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1000000;
        err_total++;
        final_report();
    end
    initial
    begin
        rstn = 1'b0;
        bus = '0;
        rxChar = '0;
        irRxIn = 1'b0;
        sendReq = 1'b0;
        rxLevel = 8'h00;
        rxTrigger = 8'h40;
        trigStep = 8'h04;
        waitclk(2);
        rstn <= 1'b1;
        waitclk(4);
        rd(ADDR_SCRATCH, v); chk("scratch", v, 8'hFF);
        rd(ADDR_ENH_FEATURE, v); chk("enhFeature", v, 8'h00);
        rd(ADDR_FEATURE, v); chk("feature", v, 8'h00);
        chk("gated", intEnableOut | fifoControlOut | modemControlOut, 8'h00);
        chk("rtsN", {7'h0, rtsN}, 8'h01);
        wr(ADDR_SCRATCH, 8'h5A);
        rd(ADDR_SCRATCH, v); chk("scratch", v, 8'h5A);
        rd(4'hF, v); chk("unmapped", v, 8'h00);
        // Enhanced bits refused while enable is clear
        wr(ADDR_INT_ENABLE, 8'hFF);
        wr(ADDR_MODEM_CONTROL, 8'hFF);
        chk("intEnable", intEnableOut & INT_ENABLE_ENH_MASK, 8'h00);
        chk("modemControl", modemControlOut & MODEM_CONTROL_ENH_MASK, 8'h00);
        setEnhFeature(8'h10);
        wr(ADDR_INT_ENABLE, 8'hFF);
        wr(ADDR_FIFO_CONTROL, 8'hFF);
        wr(ADDR_MODEM_CONTROL, 8'hFF);
        wr(ADDR_ENH_FEATURE, 8'h00);
        wr(ADDR_INT_ENABLE, 8'h00);
        wr(ADDR_FIFO_CONTROL, 8'h00);
        wr(ADDR_MODEM_CONTROL, 8'h00);
        chk("intEnable", intEnableOut & INT_ENABLE_ENH_MASK, 8'hF0);
        chk("fifoControl", fifoControlOut & FIFO_CONTROL_ENH_MASK, 8'h30);
        chk("modemControl", modemControlOut & MODEM_CONTROL_ENH_MASK, 8'hE0);
        // Infrared polarity
        irRxIn <= 1'b1;
        waitclk(6);
        chk("ir", {7'h0, irRxDecoded}, 8'h01);
        wr(ADDR_FEATURE, 8'h10);
        waitclk(4);
        chk("ir", {7'h0, irRxDecoded}, 8'h00);
        irRxIn <= 1'b0;
        waitclk(6);
        chk("ir", {7'h0, irRxDecoded}, 8'h01);
        // Transmit flow selection, every code
        for (int c = 0; c < 4; c++)
        begin
            setEnhFeature({4'h1, c[1:0], 2'b00});
            chk("txFlowSel", {6'h0, txFlowSel}, {6'h0, c[1:0]});
        end
        wr(ADDR_RES1, 8'h11);
        wr(ADDR_RES2, 8'h21);
        wr(ADDR_PAU1, 8'h13);
        wr(ADDR_PAU2, 8'h23);
        setEnhFeature(8'h12);
        sendc(8'h13); chk("cmp10", {6'h0, seen[1:0]}, 8'h01);
        sendc(8'h11); chk("cmp10", {6'h0, seen[1:0]}, 8'h02);
        sendc(8'h93); chk("cmp10", {6'h0, seen[1:0]}, 8'h00);
        sendc(8'h23); chk("cmp10", {6'h0, seen[1:0]}, 8'h00);
        setEnhFeature(8'h11);
        sendc(8'h23); chk("cmp01", {6'h0, seen[1:0]}, 8'h01);
        sendc(8'h13); chk("cmp01", {6'h0, seen[1:0]}, 8'h00);
        setEnhFeature(8'h13);
        sendc(8'h11); chk("seq", {6'h0, seen[1:0]}, 8'h00);
        sendc(8'h21); chk("seq", {6'h0, seen[1:0]}, 8'h02);
        sendc(8'h42);
        sendc(8'h21); chk("seq", {6'h0, seen[1:0]}, 8'h00);
        setEnhFeature(8'h1B);
        sendc(8'h21); chk("either", {6'h0, seen[1:0]}, 8'h02);
        sendc(8'h13); chk("either", {6'h0, seen[1:0]}, 8'h01);
        // Special character with receive codes 10 and 01
        setEnhFeature(8'h32);
        sendc(8'h55); chk("store", {7'h0, seen[2]}, 8'h01);
        chk("specialSeen", {7'h0, spec}, 8'h00);
        sendc(8'h23); chk("special10", {5'h0, seen}, 8'h04);
        chk("specialSeen", {7'h0, spec}, 8'h01);
        rd(ADDR_INT_SOURCE, v); chk("intSource", v & 8'h10, 8'h10);
        rd(ADDR_INT_SOURCE, v); chk("intSource", v & 8'h10, 8'h00);
        setEnhFeature(8'h31);
        sendc(8'h23); chk("special01", {5'h0, seen}, 8'h01);
        chk("specialSeen", {7'h0, spec}, 8'h01);
        rd(ADDR_INT_SOURCE, v); chk("intSource", v & 8'h30, 8'h30);
        // Flow-control thresholds, table A then every table D entry
        wr(ADDR_FEATURE, 8'h05);
        level(8'h00, 1'b0);
        level(8'h43, 1'b0);
        level(8'h44, 1'b1);
        level(8'h3B, 1'b0);
        for (int h = 0; h < 16; h++)
        begin
            wr(ADDR_FEATURE, {4'hC, h[3:0]});
            v = (h == 0) ? 8'h04 : hy[h];
            level(8'h00, 1'b0);
            level(8'h40 + v - 8'h01, 1'b0);
            level(8'h40 + v, 1'b1);
            level(8'h40 - v - 8'h01, 1'b0);
        end
        // Transmit interrupt and direction control
        wr(ADDR_FEATURE, 8'h00);
        sendReq <= 1'b1;
        waitclk(1);
        sendReq <= 1'b0;
        waitclk(10);
        chk("txInt", {6'h0, holdEmpty, txIntCond}, 8'h03);
        wait (shiftEmpty === 1'b1);
        setEnhFeature(8'h10);
        wr(ADDR_MODEM_STATUS, 8'h30);
        wr(ADDR_FEATURE, 8'h20);
        waitclk(30);
        chk("rtsN", {7'h0, rtsN}, 8'h00);
        sendReq <= 1'b1;
        waitclk(1);
        sendReq <= 1'b0;
        waitclk(2);
        chk("rtsN", {7'h0, rtsN}, 8'h01);
        waitclk(8);
        chk("txInt", {6'h0, holdEmpty, txIntCond}, 8'h02);
        for (int i = 0; i < 200 && shiftEmpty !== 1'b1; i++)
            waitclk(1);
        chk("txInt", {7'h0, txIntCond}, 8'h01);
        tick(2);
        chk("rtsN", {7'h0, rtsN}, 8'h01);
        tick(2);
        chk("rtsN", {7'h0, rtsN}, 8'h00);
        final_report();
    end
endmodule // uefc_top_tb
